// ===== hw/aop_regs.vh
// Register offsets, field positions and reset values of the pad/power bank
`ifndef AOP_REGS_VH
`define AOP_REGS_VH

`define AOP_ADDR_PAD_LATCH    32'h5000_030C
`define AOP_ADDR_SLEEP_WAKE   32'h5000_0310
`define AOP_ADDR_PULL_BYPASS  32'h5000_0314
`define AOP_ADDR_POWER_CTRL   32'h5000_0320
`define AOP_ADDR_MISC_DATA    32'h5000_0324
`define AOP_ADDR_STATUS       32'h5000_0328

`define AOP_RST_PAD_LATCH     1'h1
`define AOP_RST_SLEEP_WAKE    7'h00
`define AOP_RST_PULL_BYPASS   1'h1
`define AOP_RST_POWER_CTRL    15'h0008
`define AOP_RST_MISC_DATA     8'h00

`define AOP_SW_HIBERN_EN      0
`define AOP_SW_POLARITY       1
`define AOP_SW_MASK_LSB       2
`define AOP_SW_MASK_MSB       6

`define AOP_PC_RAIL_RES_LSB   0
`define AOP_PC_RAIL_RES_MSB   1
`define AOP_PC_POR_LOW_MASK   2
`define AOP_PC_POR_HIGH_MASK  3
`define AOP_PC_CHARGE_OFF     6
`define AOP_PC_CONV_LSB       7
`define AOP_PC_CONV_MSB       8
`define AOP_PC_CMP_SLP_OFF    9
`define AOP_PC_CLAMP_LSB      10
`define AOP_PC_CLAMP_MSB      13

`define AOP_MD_SCRATCH_LSB    0
`define AOP_MD_SCRATCH_MSB    3
`define AOP_MD_BIAS_TO_REF    5
`define AOP_MD_BIAS_TO_SUPPLY 6
`define AOP_MD_FILTER_OFF     7

`define AOP_ST_WAKE_FLAG      0
`define AOP_ST_BOOST          1
`define AOP_ST_STATE_LSB      2
`define AOP_ST_STATE_MSB      3

`endif

// ===== hw/aop_sync.v
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module aop_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_clk,   // System clock
  input  wire             i_rst_b, // Synchronous reset, active low
  input  wire [WIDTH-1:0] i_async, // Asynchronous levels
  output reg  [WIDTH-1:0] o_sync   // Levels safe to read
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta   <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule // aop_sync

`default_nettype wire

// ===== hw/aop_ctrl.v
// Always-on pad retention, sleep depth, wake and power control bank
//
// What this block does
// - Pad latches closed at 0, open at 1
// - Five-bit mask picks hibernation wake pins
// - Wake flag reads 1; pin change clears, wakes
// - Enable 0 deep sleep, 1 hibernation
// - Pull bypass forces pull-up in boost mode
// - Four-bit clamp level used in hibernation
// - Bit 9 disables supply comparator in sleep
// - Converter mode: auto, force boost, force buck
// - Bit 6 stops battery charging in boost
// - Bits 3,2 mask rail power-on resets
// - Rail resistor: off, on, sleep-on, auto
// - Bit 7 disables slow crystal pin filter
// - Bit 6 ties oscillator bias to supply
// - Bit 5 ties oscillator bias to reference
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "aop_regs.vh"

module aop_ctrl #(
  parameter NUM_WAKE = 5
) (
  input  wire                I_CLK,          // 250 MHz system clock
  input  wire                I_RST_B,        // Sync reset, active low
  input  wire [31:0]         I_ADDR,         // Register byte address
  input  wire [31:0]         I_WDATA,        // Write data
  input  wire                I_WR,           // Write strobe
  input  wire                I_RD,           // Read strobe
  output reg  [31:0]         O_RDATA,        // Read data, cycle after
  input  wire                I_SLEEP_REQ,    // System asks to sleep
  input  wire [NUM_WAKE-1:0] I_WAKE_PIN,     // Wake-capable pins
  input  wire                I_BOOST_DET,    // Analog boost detect
  input  wire                I_RAIL_AUTO,    // Resistor auto request
  input  wire                I_POR_HIGH,     // High rail POR detect
  input  wire                I_POR_LOW,      // Low rail POR detect
  output reg                 O_PAD_LATCH_OPEN, // Pad latches open
  output reg                 O_SLEEP_PD_ON,  // Sleep domain powered
  output reg                 O_WAKE,         // Wake pulse
  output reg                 O_BOOST_MODE,   // Converter in boost
  output reg                 O_PULLUP_FORCE, // Force wake pad pull-up
  output reg  [3:0]          O_CLAMP_LEVEL,  // Clamp level
  output reg                 O_CLAMP_ACTIVE, // Clamp level applied
  output reg                 O_CMP_OFF,      // Comparator disabled
  output reg                 O_CHARGE_OFF,   // Battery charge stopped
  output reg                 O_POR_RST,      // Unmasked POR reset
  output reg                 O_RAIL_RES_ON,  // Rail resistor on
  output reg                 O_FILTER_OFF,   // Slow xtal filter off
  output reg                 O_BIAS_SUPPLY,  // Osc bias to supply
  output reg                 O_BIAS_REF      // Osc bias to reference
);

  localparam ST_ACTIVE = 2'b00;
  localparam ST_DEEP   = 2'b01;
  localparam ST_HIBERN = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  reg        pad_state_retention_ctrl;
  reg [6:0]  sleep_depth_wake_ctrl;
  reg        forced_pullup_bypass;
  reg [14:0] always_on_power_ctrl;
  reg [7:0]  misc_filter_bias_scratch;

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg        next_wake;

  wire [NUM_WAKE-1:0] pin_sync;
  wire [2:0]          ana_sync;
  wire                rail_auto_sync;

  wire [4:0] deep_wake_pin_select;
  wire       deep_wake_polarity;
  wire       hibern_enable;
  wire       forced_pullup_on;
  wire [3:0] retention_clamp_level;
  wire       supply_comparator_sleep_off;
  wire [1:0] conv_mode;
  wire       charge_disable;
  wire       por_high_mask;
  wire       por_low_mask;
  wire [1:0] rail_link_resistor_mode;
  wire       slow_xtal_pin_filter_off;
  wire       rc_osc_bias_to_supply;
  wire       rc_osc_bias_to_reference;
  wire [3:0] software_scratch_bits;

  wire       clockless_wake_flag;
  wire       boost_now;
  wire       sleeping;
  wire       hibernating;
  reg        rail_res_next;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Pins and analog detectors are asynchronous to the bank clock
  aop_sync #(
    .WIDTH (NUM_WAKE)
  ) u_pin_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_WAKE_PIN),
    .o_sync  (pin_sync)
  );

  aop_sync #(
    .WIDTH (3)
  ) u_ana_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async ({I_POR_LOW, I_POR_HIGH, I_BOOST_DET}),
    .o_sync  (ana_sync)
  );

  // The resistor request comes from the analog side as well
  aop_sync #(
    .WIDTH (1)
  ) u_rail_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_RAIL_AUTO),
    .o_sync  (rail_auto_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Field views

  // Named slices of the stored words; reserved bits have none
  assign hibern_enable =
    sleep_depth_wake_ctrl[`AOP_SW_HIBERN_EN];
  assign deep_wake_polarity =
    sleep_depth_wake_ctrl[`AOP_SW_POLARITY];
  assign deep_wake_pin_select =
    sleep_depth_wake_ctrl[`AOP_SW_MASK_MSB:`AOP_SW_MASK_LSB];
  assign forced_pullup_on = forced_pullup_bypass;
  assign retention_clamp_level =
    always_on_power_ctrl[`AOP_PC_CLAMP_MSB:`AOP_PC_CLAMP_LSB];
  assign supply_comparator_sleep_off =
    always_on_power_ctrl[`AOP_PC_CMP_SLP_OFF];
  assign conv_mode =
    always_on_power_ctrl[`AOP_PC_CONV_MSB:`AOP_PC_CONV_LSB];
  assign charge_disable = always_on_power_ctrl[`AOP_PC_CHARGE_OFF];
  assign por_high_mask = always_on_power_ctrl[`AOP_PC_POR_HIGH_MASK];
  assign por_low_mask = always_on_power_ctrl[`AOP_PC_POR_LOW_MASK];
  assign rail_link_resistor_mode =
    always_on_power_ctrl[`AOP_PC_RAIL_RES_MSB:`AOP_PC_RAIL_RES_LSB];
  assign slow_xtal_pin_filter_off =
    misc_filter_bias_scratch[`AOP_MD_FILTER_OFF];
  assign rc_osc_bias_to_supply =
    misc_filter_bias_scratch[`AOP_MD_BIAS_TO_SUPPLY];
  assign rc_osc_bias_to_reference =
    misc_filter_bias_scratch[`AOP_MD_BIAS_TO_REF];
  assign software_scratch_bits =
    misc_filter_bias_scratch[`AOP_MD_SCRATCH_MSB:`AOP_MD_SCRATCH_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Wake flag and converter mode

  // Flag is 1 while every selected pin matches the polarity level
  // It reads back in the status word in every state, so software can check its
  // polarity choice before it asks for hibernation
  assign clockless_wake_flag =
    ~|(deep_wake_pin_select &
       (pin_sync[4:0] ^ {5{deep_wake_polarity}}));

  // Upper bit 0 follows detection, 11 boost, 10 buck
  assign boost_now = conv_mode[1] ? conv_mode[0]
                                  : ana_sync[0];

  assign sleeping    = (state != ST_ACTIVE);
  assign hibernating = (state == ST_HIBERN);

  ////////////////////////////////////////////////////////////////////////
  // Sleep sequencing

  // Depth is chosen at sleep entry; a later write to the enable bit
  // does not move an already sleeping domain.
  always @* begin
    next_state = state;
    next_wake  = 1'b0;
    case (state)
      ST_ACTIVE: begin
        if (I_SLEEP_REQ) begin
          if (hibern_enable) begin
            next_state = ST_HIBERN;
          end else begin
            next_state = ST_DEEP;
          end
        end
      end
      ST_DEEP: begin
        // Deep sleep keeps the domain up and ignores the wake pins
        if (!I_SLEEP_REQ) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_HIBERN: begin
        // Software must have set the boot remap before this point
        // since the sleep domain loses power here.
        if (!clockless_wake_flag) begin
          next_state = ST_ACTIVE;
          next_wake  = 1'b1;
        end else if (!I_SLEEP_REQ) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      state  <= ST_ACTIVE;
      O_WAKE <= 1'b0;
    end else begin
      state  <= next_state;
      O_WAKE <= next_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  // Reserved bits inside a register are kept and read back; bits
  // above its width and writes to the status word are dropped
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      pad_state_retention_ctrl <= `AOP_RST_PAD_LATCH;
      sleep_depth_wake_ctrl    <= `AOP_RST_SLEEP_WAKE;
      forced_pullup_bypass     <= `AOP_RST_PULL_BYPASS;
      always_on_power_ctrl     <= `AOP_RST_POWER_CTRL;
      misc_filter_bias_scratch <= `AOP_RST_MISC_DATA;
    end else if (I_WR) begin
      if (I_ADDR == `AOP_ADDR_PAD_LATCH) begin
        pad_state_retention_ctrl <= I_WDATA[0];
      end else if (I_ADDR == `AOP_ADDR_SLEEP_WAKE) begin
        sleep_depth_wake_ctrl <= I_WDATA[6:0];
      end else if (I_ADDR == `AOP_ADDR_PULL_BYPASS) begin
        forced_pullup_bypass <= I_WDATA[0];
      end else if (I_ADDR == `AOP_ADDR_POWER_CTRL) begin
        always_on_power_ctrl <= I_WDATA[14:0];
      end else if (I_ADDR == `AOP_ADDR_MISC_DATA) begin
        misc_filter_bias_scratch <= I_WDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads

  // Unmapped addresses read as zero; the bus never waits
  // Status word: bit 0 wake flag, bit 1 resolved boost mode,
  // bits 3:2 sleep state; it is read-only
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      if (I_ADDR == `AOP_ADDR_PAD_LATCH) begin
        O_RDATA <= {31'h0000_0000, pad_state_retention_ctrl};
      end else if (I_ADDR == `AOP_ADDR_SLEEP_WAKE) begin
        O_RDATA <= {25'h000_0000, sleep_depth_wake_ctrl};
      end else if (I_ADDR == `AOP_ADDR_PULL_BYPASS) begin
        O_RDATA <= {31'h0000_0000, forced_pullup_bypass};
      end else if (I_ADDR == `AOP_ADDR_POWER_CTRL) begin
        O_RDATA <= {17'h0_0000, always_on_power_ctrl};
      end else if (I_ADDR == `AOP_ADDR_MISC_DATA) begin
        O_RDATA <= {24'h00_0000, misc_filter_bias_scratch[7:4],
                    software_scratch_bits};
      end else if (I_ADDR == `AOP_ADDR_STATUS) begin
        O_RDATA <= {28'h000_0000, state, boost_now,
                    clockless_wake_flag};
      end else begin
        O_RDATA <= 32'h0000_0000;
      end
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Resistor mode decode

  // Mode 10 counts both sleep depths as sleep
  always @* begin
    case (rail_link_resistor_mode)
      2'b00:   rail_res_next = 1'b0;
      2'b01:   rail_res_next = 1'b1;
      2'b10:   rail_res_next = sleeping | rail_auto_sync;
      default: rail_res_next = rail_auto_sync;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control outputs

  // One register stage on every control keeps glitches off analog
  // Pull-up and charge controls use the same resolved mode as the
  // boost output, so the three never disagree in a cycle
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_PAD_LATCH_OPEN <= 1'b1;
      O_SLEEP_PD_ON    <= 1'b1;
      O_BOOST_MODE     <= 1'b0;
      O_PULLUP_FORCE   <= 1'b0;
      O_CLAMP_LEVEL    <= 4'h0;
      O_CLAMP_ACTIVE   <= 1'b0;
      O_CMP_OFF        <= 1'b0;
      O_CHARGE_OFF     <= 1'b0;
      O_POR_RST        <= 1'b0;
      O_RAIL_RES_ON    <= 1'b0;
      O_FILTER_OFF     <= 1'b0;
      O_BIAS_SUPPLY    <= 1'b0;
      O_BIAS_REF       <= 1'b0;
    end else begin
      O_PAD_LATCH_OPEN <= pad_state_retention_ctrl;
      O_SLEEP_PD_ON    <= ~hibernating;
      O_BOOST_MODE     <= boost_now;
      O_PULLUP_FORCE   <= forced_pullup_on & boost_now;
      O_CLAMP_LEVEL    <= retention_clamp_level;
      O_CLAMP_ACTIVE   <= hibernating;
      O_CMP_OFF        <= supply_comparator_sleep_off & sleeping;
      O_CHARGE_OFF     <= charge_disable & boost_now;
      // A detector pulse shorter than a clock period can be missed
      O_POR_RST        <= (ana_sync[1] & ~por_high_mask) |
                          (ana_sync[2] & ~por_low_mask);
      O_RAIL_RES_ON    <= rail_res_next;
      O_FILTER_OFF     <= slow_xtal_pin_filter_off;
      O_BIAS_SUPPLY    <= rc_osc_bias_to_supply;
      O_BIAS_REF       <= rc_osc_bias_to_reference;
    end
  end

endmodule // aop_ctrl

`default_nettype wire

// ===== dv/aop_ctrl_monitor.sv
// Assertion checker for the always-on pad and power control bank
`timescale 1ns/1ps
`default_nettype none
`include "aop_regs.vh"

module aop_ctrl_monitor (
  input wire        I_CLK,            // Clock
  input wire        I_RST_B,          // Reset, active low
  input wire [31:0] I_ADDR,           // Address
  input wire [31:0] I_WDATA,          // Write data
  input wire        I_WR,             // Write strobe
  input wire        O_PAD_LATCH_OPEN, // Latch open
  input wire        O_SLEEP_PD_ON,    // Sleep domain on
  input wire        O_WAKE,           // Wake pulse
  input wire        O_BOOST_MODE,     // Boost
  input wire        O_PULLUP_FORCE,   // Pull-up forced
  input wire [3:0]  O_CLAMP_LEVEL,    // Clamp level
  input wire        O_CLAMP_ACTIVE,   // Clamp applied
  input wire        O_CMP_OFF,        // Comparator off
  input wire        O_CHARGE_OFF,     // Charge stopped
  input wire        O_RAIL_RES_ON,    // Rail resistor
  input wire        O_FILTER_OFF,     // Filter off
  input wire        O_BIAS_SUPPLY,    // Bias to supply
  input wire        O_BIAS_REF        // Bias to reference
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  wire wr_pad  = I_WR && I_ADDR == `AOP_ADDR_PAD_LATCH;
  wire wr_pwr  = I_WR && I_ADDR == `AOP_ADDR_POWER_CTRL;
  wire wr_misc = I_WR && I_ADDR == `AOP_ADDR_MISC_DATA;
  //////////////////////////////////////////////////////////////////////////
  a_pad_latch_follow: assert property (
    wr_pad |-> ##2 O_PAD_LATCH_OPEN == $past(I_WDATA[0], 2))
    else $error("pad latch output does not follow write");
  a_clamp_level_follow: assert property (
    wr_pwr |-> ##2 O_CLAMP_LEVEL == $past(I_WDATA[13:10], 2))
    else $error("clamp level does not follow write");
  a_conv_force_mode: assert property (
    wr_pwr && I_WDATA[8] |-> ##2 O_BOOST_MODE == $past(I_WDATA[7], 2))
    else $error("forced converter mode not applied");
  a_rail_res_fixed: assert property (
    wr_pwr && !I_WDATA[1] |-> ##2 O_RAIL_RES_ON == $past(I_WDATA[0], 2))
    else $error("fixed rail resistor mode not applied");
  a_cmp_needs_bit: assert property (
    wr_pwr && !I_WDATA[9] |-> ##2 !O_CMP_OFF)
    else $error("comparator off without its bit");
  a_misc_bits_follow: assert property (
    wr_misc |-> ##2
      {O_FILTER_OFF, O_BIAS_SUPPLY, O_BIAS_REF} == $past(I_WDATA[7:5], 2))
    else $error("filter or bias outputs do not follow write");
  a_pullup_needs_boost: assert property (
    O_PULLUP_FORCE |-> O_BOOST_MODE)
    else $error("pull-up forced outside boost");
  a_charge_needs_boost: assert property (
    O_CHARGE_OFF |-> O_BOOST_MODE)
    else $error("charge stopped outside boost");
  a_hib_clamp_pd: assert property (
    O_CLAMP_ACTIVE != O_SLEEP_PD_ON)
    else $error("sleep domain and clamp disagree");
  a_wake_one_cycle: assert property (
    O_WAKE |=> !O_WAKE ##0 O_SLEEP_PD_ON)
    else $error("wake pulse too long or domain still off");
  c_power_write: cover property (wr_pwr);
  c_wake_seen: cover property (O_WAKE);
  c_cmp_off: cover property (O_CMP_OFF);
endmodule // aop_ctrl_monitor

bind aop_ctrl aop_ctrl_monitor aop_ctrl_monitor_i (
  .I_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .O_PAD_LATCH_OPEN,
  .O_SLEEP_PD_ON, .O_WAKE, .O_BOOST_MODE, .O_PULLUP_FORCE, .O_CLAMP_LEVEL,
  .O_CLAMP_ACTIVE, .O_CMP_OFF, .O_CHARGE_OFF, .O_RAIL_RES_ON,
  .O_FILTER_OFF, .O_BIAS_SUPPLY, .O_BIAS_REF);
`default_nettype wire

// ===== dv/aop_ctrl_tb_top.sv
// Self-checking bench for the always-on pad and power control bank
`timescale 1ns/1ps
`default_nettype none
`include "aop_regs.vh"

module aop_ctrl_tb_top;
  logic        I_CLK, I_RST_B, I_WR, I_RD, I_SLEEP_REQ, I_BOOST_DET;
  logic        I_RAIL_AUTO, I_POR_HIGH, I_POR_LOW;
  logic [31:0] I_ADDR, I_WDATA;
  logic [4:0]  I_WAKE_PIN;
  wire  [31:0] O_RDATA;
  wire  [3:0]  O_CLAMP_LEVEL;
  wire         O_PAD_LATCH_OPEN, O_SLEEP_PD_ON, O_WAKE, O_BOOST_MODE;
  wire         O_PULLUP_FORCE, O_CLAMP_ACTIVE, O_CMP_OFF, O_CHARGE_OFF;
  wire         O_POR_RST, O_RAIL_RES_ON, O_FILTER_OFF, O_BIAS_SUPPLY;
  wire         O_BIAS_REF;
  int          n_mismatch, checks_done;

  aop_ctrl aop_ctrl_i (.I_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
    .O_RDATA, .I_SLEEP_REQ, .I_WAKE_PIN, .I_BOOST_DET, .I_RAIL_AUTO,
    .I_POR_HIGH, .I_POR_LOW, .O_PAD_LATCH_OPEN, .O_SLEEP_PD_ON, .O_WAKE,
    .O_BOOST_MODE, .O_PULLUP_FORCE, .O_CLAMP_LEVEL, .O_CLAMP_ACTIVE,
    .O_CMP_OFF, .O_CHARGE_OFF, .O_POR_RST, .O_RAIL_RES_ON, .O_FILTER_OFF,
    .O_BIAS_SUPPLY, .O_BIAS_REF);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [31:0] a, exp, input string what);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, exp, what);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(`AOP_ADDR_PAD_LATCH, 32'h0000_0001, "pad reset");
    rd(`AOP_ADDR_SLEEP_WAKE, 32'h0000_0000, "sleep reset");
    rd(`AOP_ADDR_PULL_BYPASS, 32'h0000_0001, "bypass reset");
    rd(`AOP_ADDR_POWER_CTRL, 32'h0000_0008, "power reset");
    rd(`AOP_ADDR_MISC_DATA, 32'h0000_0000, "misc reset");
    chk(O_PAD_LATCH_OPEN, 1, "latch open at reset");
  endtask
  task automatic t_readback;
    logic [31:0] adr [5] = '{`AOP_ADDR_PAD_LATCH, `AOP_ADDR_SLEEP_WAKE,
      `AOP_ADDR_PULL_BYPASS, `AOP_ADDR_POWER_CTRL, `AOP_ADDR_MISC_DATA};
    logic [31:0] msk [5] = '{32'h0000_0001, 32'h0000_007F, 32'h0000_0001,
      32'h0000_7FFF, 32'h0000_00FF};
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 32'hFFFF_FFFF);
      rd(adr[i], msk[i], "ones readback");
      wr(adr[i], 32'h0000_0000);
      rd(adr[i], 32'h0000_0000, "zero readback");
    end
    chk(O_PAD_LATCH_OPEN, 0, "latch closed");
    wr(`AOP_ADDR_PAD_LATCH, 32'h0000_0001);
    wr(32'h5000_0318, 32'hFFFF_FFFF);
    rd(32'h5000_0318, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_misc;
    logic [31:0] d [2] = '{32'h0000_00A5, 32'h0000_0040};
    for (int i = 0; i < 2; i++) begin
      wr(`AOP_ADDR_MISC_DATA, d[i]);
      chk(O_FILTER_OFF, d[i][7], "filter off");
      chk(O_BIAS_SUPPLY, d[i][6], "bias to supply");
      chk(O_BIAS_REF, d[i][5], "bias to reference");
      rd(`AOP_ADDR_MISC_DATA, d[i], "misc readback");
    end
  endtask
  task automatic t_power;
    @(posedge I_CLK);
    I_BOOST_DET <= 1'b1;
    wr(`AOP_ADDR_PULL_BYPASS, 32'h0000_0001);
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_3DC1);
    chk(O_CLAMP_LEVEL, 4'hF, "clamp level");
    chk(O_CHARGE_OFF, 1, "charge off in boost");
    chk(O_PULLUP_FORCE, 1, "pull-up in boost");
    chk(O_RAIL_RES_ON, 1, "rail forced on");
    wr(`AOP_ADDR_PULL_BYPASS, 32'h0000_0000);
    chk(O_PULLUP_FORCE, 0, "pull-up normal");
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_0100);
    chk(O_BOOST_MODE, 0, "forced buck");
    chk(O_RAIL_RES_ON, 0, "rail off");
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_0003);
    chk(O_BOOST_MODE, 1, "auto boost");
    chk(O_RAIL_RES_ON, 0, "rail auto idle");
    I_RAIL_AUTO <= 1'b1;
    I_POR_HIGH <= 1'b1;
    cyc(5);
    chk(O_RAIL_RES_ON, 1, "rail auto request");
    chk(O_POR_RST, 1, "high por unmasked");
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_0008);
    chk(O_POR_RST, 0, "high por masked");
    I_POR_LOW <= 1'b1;
    I_BOOST_DET <= 1'b0;
    cyc(5);
    chk(O_POR_RST, 1, "low por unmasked");
    chk(O_BOOST_MODE, 0, "auto buck");
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_000C);
    chk(O_POR_RST, 0, "low por masked");
  endtask
  task automatic t_sleep;
    I_RAIL_AUTO <= 1'b0;
    wr(`AOP_ADDR_POWER_CTRL, 32'h0000_020A);
    chk(O_RAIL_RES_ON, 0, "rail auto when active");
    I_SLEEP_REQ <= 1'b1;
    cyc(3);
    chk(O_SLEEP_PD_ON, 1, "deep sleep domain on");
    chk(O_CMP_OFF, 1, "comparator off in sleep");
    chk(O_RAIL_RES_ON, 1, "rail on in sleep");
    rd(`AOP_ADDR_STATUS, 32'h0000_0005, "deep sleep status");
    I_SLEEP_REQ <= 1'b0;
    wr(`AOP_ADDR_SLEEP_WAKE, 32'h0000_0005);
    rd(`AOP_ADDR_STATUS, 32'h0000_0001, "wake flag set");
    I_SLEEP_REQ <= 1'b1;
    cyc(3);
    chk(O_SLEEP_PD_ON, 0, "hibernation domain off");
    chk(O_CLAMP_ACTIVE, 1, "clamp in hibernation");
    rd(`AOP_ADDR_STATUS, 32'h0000_0009, "hibernation status");
    I_WAKE_PIN <= 5'h02;
    cyc(6);
    chk(O_SLEEP_PD_ON, 0, "unselected pin woke");
    I_WAKE_PIN <= 5'h03;
    repeat (2) @(posedge I_CLK);
    I_SLEEP_REQ <= 1'b0;
    for (int i = 0; i < 8 && O_WAKE !== 1'b1; i++) cyc(1);
    chk(O_WAKE, 1, "wake pulse");
    cyc(2);
    chk(O_SLEEP_PD_ON, 1, "domain back on");
  endtask
  task automatic t_mid_reset;
    wr(`AOP_ADDR_PAD_LATCH, 32'h0000_0000);
    @(posedge I_CLK);
    I_RST_B <= 1'b0;
    repeat (5) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    t_reset();
    chk(O_POR_RST, 1, "low por after reset");
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  initial begin
    {I_RST_B, I_WR, I_RD, I_SLEEP_REQ, I_BOOST_DET} = '0;
    {I_RAIL_AUTO, I_POR_HIGH, I_POR_LOW} = '0;
    {I_ADDR, I_WDATA, I_WAKE_PIN} = '0;
    repeat (5) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    t_reset();
    t_readback();
    t_misc();
    t_power();
    t_mid_reset();
    t_sleep();
    final_report();
  end
  // Whole run is a few hundred cycles; 2000 leaves ample margin
  initial begin
    #8000;
    n_mismatch++;
    final_report();
  end
endmodule // aop_ctrl_tb_top
`default_nettype wire
